/* File: count_bus_if.sv */
`timescale 1ns/100ps
interface count_bus_if;
	logic            tick;
	logic            wrap;
	pwm_pkg::count_t count;
	logic [1:0]      len;

	modport src (output tick, output wrap, output count, input len);
	modport snk (input tick, input wrap, input count, input len);
endinterface : count_bus_if

/* File: count_timebase.sv */
`timescale 1ns/100ps
`include "pwm_channel_defines.svh"
module count_timebase (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	// Control
	input  wire logic        run,
	input  wire logic [7:0]  div,
	input  wire logic        cnt_wr,
	input  wire logic [10:0] cnt_wdata,
	// Shared count
	count_bus_if.src         bus
);
	pwm_pkg::tb_state_t s_r;
	pwm_pkg::tb_state_t s_nxt;

	// One tick every div+1 system clocks
	assign bus.tick  = run && (s_r.pre == div);
	assign bus.wrap  = bus.tick && (s_r.cnt == pwm_pkg::len_max(bus.len));
	assign bus.count = s_r.cnt;

	always_comb begin
		s_nxt = s_r;
		if (!run || bus.tick) begin
			s_nxt.pre = `RST_BYTE;
		end else begin
			s_nxt.pre = s_r.pre + 8'h01;
		end
		if (cnt_wr) begin
			s_nxt.cnt = cnt_wdata & pwm_pkg::len_max(bus.len);
		end else if (bus.tick) begin
			s_nxt.cnt = pwm_pkg::nxt_count(s_r.cnt, bus.len);
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= '{pre: `RST_BYTE, cnt: `RST_CNT};
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule : count_timebase

/* File: counter_array_pwm_channel.sv */
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/100ps
`include "pwm_channel_defines.svh"
module counter_array_pwm_channel (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Channel pin and interrupt
	output logic             channel_output_pin,
	output logic             irq
);
	pwm_pkg::top_state_t s_r;
	pwm_pkg::top_state_t s_nxt;
	count_bus_if         cnt_bus ();
	logic                acc;
	logic                wr;
	logic                wr_cmpl;
	logic                wr_cmph;
	logic                cnt_wr;
	logic                active;
	logic                mode8;
	logic [10:0]         cmp_val;
	logic                pin;
	logic                match;
	logic                ovf;

	function automatic logic mapped(input logic [11:0] a);
		case (a)
			`A_MODE, `A_CMPL, `A_CMPH, `A_CFG,
			`A_STAT, `A_MASK, `A_CTRL, `A_CNT: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : mapped

	function automatic logic [31:0] rd_word(
		input logic [11:0]         a,
		input pwm_pkg::top_state_t s,
		input pwm_pkg::count_t     c
	);
		logic [31:0] d;
		d = `RST_WORD;
		case (a)
			`A_MODE: begin
				d[`B_CMP_EN]  = s.cmp_en;
				d[`B_FLAG_EN] = s.flag_en;
				d[`B_PWM]     = s.pwm;
			end
			`A_CMPL: d = {`PAD24, s.cmpl};
			`A_CMPH: d = {`PAD24, s.cmph};
			`A_CFG: begin
				d[`F_LEN_MSB:`F_LEN_LSB] = s.len;
				d[`B_OVF_MIR]            = s.stat[`S_OVF];
			end
			`A_STAT: d = {`PAD30, s.stat};
			`A_MASK: d = {`PAD30, s.mask};
			`A_CTRL: begin
				d[`B_RUN]                = s.run;
				d[`F_DIV_MSB:`F_DIV_LSB] = s.div;
			end
			`A_CNT:  d = {`PAD21, c};
			default: d = `RST_WORD;
		endcase
		return d;
	endfunction : rd_word

	// Access phase is the single cycle after setup; writes land here
	assign acc     = (s_r.st == pwm_pkg::BUS_RESP) && psel && penable;
	assign wr      = acc && pwrite && !s_r.pslverr;
	assign wr_cmpl = wr && (paddr == `A_CMPL);
	assign wr_cmph = wr && (paddr == `A_CMPH);
	assign cnt_wr  = wr && (paddr == `A_CNT);

	// Single length field drives every modulating channel
	assign cnt_bus.len = s_r.len;

	assign active = s_r.cmp_en && s_r.pwm;
	assign mode8  = active && (s_r.len == `LEN_8);

	// At the wrap the freshly reloaded byte is the one compared
	always_comb begin
		if (s_r.len == `LEN_8) begin
			cmp_val = {`PAD3, (cnt_bus.wrap ? s_r.cmph : s_r.cmpl)};
		end else begin
			cmp_val = {s_r.cmph[`F_HI3_MSB:0], s_r.cmpl} &
			          pwm_pkg::len_max(s_r.len);
		end
	end

	count_timebase count_timebase_i (
		.clk_sys   (clk_sys),
		.arst_n    (arst_n),
		.run       (s_r.run),
		.div       (s_r.div),
		.cnt_wr    (cnt_wr),
		.cnt_wdata (pwdata[`F_CNT_MSB:`F_CNT_LSB]),
		.bus       (cnt_bus.src)
	);

	pwm_compare pwm_compare_i (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.bus     (cnt_bus.snk),
		.active  (active),
		.cmp_val (cmp_val),
		.pin     (pin),
		.match   (match),
		.ovf     (ovf)
	);

	always_comb begin
		s_nxt = s_r;
		case (s_r.st)
			pwm_pkg::BUS_IDLE: begin
				if (psel && !penable) begin
					s_nxt.st      = pwm_pkg::BUS_RESP;
					s_nxt.pready  = 1'b1;
					s_nxt.pslverr = !mapped(paddr);
					s_nxt.prdata  = pwrite ? `RST_WORD :
					                rd_word(paddr, s_r, cnt_bus.count);
				end
			end
			pwm_pkg::BUS_RESP: begin
				if (psel && penable) begin
					s_nxt.st      = pwm_pkg::BUS_IDLE;
					s_nxt.pready  = 1'b0;
					s_nxt.pslverr = 1'b0;
					s_nxt.prdata  = `RST_WORD;
				end
			end
			default: begin
				s_nxt.st      = pwm_pkg::BUS_IDLE;
				s_nxt.pready  = 1'b0;
				s_nxt.pslverr = 1'b0;
				s_nxt.prdata  = `RST_WORD;
			end
		endcase

		if (s_r.len == `LEN_8 && cnt_bus.wrap) begin
			s_nxt.cmpl = s_r.cmph;
		end

		if (wr) begin
			case (paddr)
				`A_MODE: begin
					s_nxt.cmp_en  = pwdata[`B_CMP_EN];
					s_nxt.flag_en = pwdata[`B_FLAG_EN];
					s_nxt.pwm     = pwdata[`B_PWM];
				end
				`A_CMPL: begin
					s_nxt.cmpl   = pwdata[`F_BYTE_MSB:`F_BYTE_LSB];
					s_nxt.cmp_en = 1'b0;
				end
				`A_CMPH: begin
					s_nxt.cmph   = pwdata[`F_BYTE_MSB:`F_BYTE_LSB];
					s_nxt.cmp_en = 1'b1;
				end
				`A_CFG:  s_nxt.len  = pwdata[`F_LEN_MSB:`F_LEN_LSB];
				`A_STAT: s_nxt.stat = s_r.stat & ~pwdata[`S_OVF:`S_EVT];
				`A_MASK: s_nxt.mask = pwdata[`S_OVF:`S_EVT];
				`A_CTRL: begin
					s_nxt.run = pwdata[`B_RUN];
					s_nxt.div = pwdata[`F_DIV_MSB:`F_DIV_LSB];
				end
				default: s_nxt.run = s_r.run;
			endcase
		end

		// Hardware set wins over a same-cycle clear
		if (match && s_r.flag_en) begin
			s_nxt.stat[`S_EVT] = 1'b1;
		end
		if (ovf) begin
			s_nxt.stat[`S_OVF] = 1'b1;
		end
		s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= pwm_pkg::TOP_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pready             = s_r.pready;
	assign prdata             = s_r.prdata;
	assign pslverr            = s_r.pslverr;
	assign channel_output_pin = pin;
	assign irq                = s_r.irq;

	property p_pin_set;
		@(posedge clk_sys) disable iff (!arst_n)
		mode8 && cnt_bus.tick &&
		(pwm_pkg::nxt_count(cnt_bus.count, s_r.len) == cmp_val) &&
		!wr_cmpl && !(wr && paddr == `A_MODE)
		|=> channel_output_pin;
	endproperty
	a_pin_set: assert property (p_pin_set)
		else $error("output not set on compare match");

	property p_pin_clr;
		@(posedge clk_sys) disable iff (!arst_n)
		mode8 && cnt_bus.wrap && (cmp_val != `RST_CNT)
		|=> !channel_output_pin;
	endproperty
	a_pin_clr: assert property (p_pin_clr)
		else $error("output not cleared on overflow");

	property p_reload;
		@(posedge clk_sys) disable iff (!arst_n)
		(s_r.len == `LEN_8) && cnt_bus.wrap && !wr_cmpl
		|=> s_r.cmpl == $past(s_r.cmph);
	endproperty
	a_reload: assert property (p_reload)
		else $error("compare low not reloaded at wrap");

	property p_mode_gate;
		@(posedge clk_sys) disable iff (!arst_n)
		$rose(channel_output_pin) |-> $past(active);
	endproperty
	a_mode_gate: assert property (p_mode_gate)
		else $error("output rose outside modulation mode");

	property p_evt;
		@(posedge clk_sys) disable iff (!arst_n)
		match && s_r.flag_en |=> s_r.stat[`S_EVT];
	endproperty
	a_evt: assert property (p_evt)
		else $error("event flag not set on match");

	property p_ovf;
		@(posedge clk_sys) disable iff (!arst_n)
		cnt_bus.wrap |=> ovf ##1 s_r.stat[`S_OVF];
	endproperty
	a_ovf: assert property (p_ovf)
		else $error("overflow flag not set after wrap");

	property p_en_wr;
		@(posedge clk_sys) disable iff (!arst_n)
		(wr_cmpl |=> !s_r.cmp_en) and (wr_cmph |=> s_r.cmp_en);
	endproperty
	a_en_wr: assert property (p_en_wr)
		else $error("compare enable not updated by compare write");

	property p_zero_duty;
		@(posedge clk_sys) disable iff (!arst_n)
		!active |=> !channel_output_pin;
	endproperty
	a_zero_duty: assert property (p_zero_duty)
		else $error("output high with compare enable clear");

	property p_count;
		@(posedge clk_sys) disable iff (!arst_n)
		cnt_bus.tick && !cnt_wr && !(wr && paddr == `A_CFG)
		|=> cnt_bus.count == pwm_pkg::nxt_count($past(cnt_bus.count),
		                                        s_r.len);
	endproperty
	a_count: assert property (p_count)
		else $error("counter did not advance on tick");

	property p_pin_steady;
		@(posedge clk_sys) disable iff (!arst_n)
		active && !cnt_bus.tick |=> $stable(channel_output_pin);
	endproperty
	a_pin_steady: assert property (p_pin_steady)
		else $error("output moved between timebase ticks");

	property p_en_hold;
		@(posedge clk_sys) disable iff (!arst_n)
		!wr |=> $stable(s_r.cmp_en);
	endproperty
	a_en_hold: assert property (p_en_hold)
		else $error("compare enable changed without a write");

	property p_flags_hold;
		@(posedge clk_sys) disable iff (!arst_n)
		!wr && !ovf && !(match && s_r.flag_en) |=> $stable(s_r.stat);
	endproperty
	a_flags_hold: assert property (p_flags_hold)
		else $error("status flags changed with no event or write");
endmodule : counter_array_pwm_channel

/* File: counter_array_pwm_channel_tb.sv */
`timescale 1ns/100ps
`include "pwm_channel_defines.svh"
module counter_array_pwm_channel_tb;
	typedef struct packed {
		logic [31:0] data;
		logic        err;
		logic        rd;
	} apb_exp_t;
	typedef struct packed {
		logic [11:0] hi;
		logic [11:0] per;
		logic        use_hi;
	} pwm_exp_t;

	logic        clk_sys;
	logic        arst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pin;
	logic        irq;
	logic        done;
	logic [11:0] high_cnt;
	logic [11:0] per_cnt;
	apb_exp_t    apb_q[$];
	pwm_exp_t    pwm_q[$];
	apb_exp_t    ae;
	pwm_exp_t    pe;
	int          n_errors;
	int          compares;
	int          cnt;
	logic [7:0]  hb;
	logic [11:0] pv;
	logic [11:0] cv;

	counter_array_pwm_channel counter_array_pwm_channel_i (
		.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .channel_output_pin(pin), .irq(irq));

	pin_load_model pin_load_model_i (
		.clk_sys(clk_sys), .arst_n(arst_n), .pin(pin), .done(done),
		.high_cnt(high_cnt), .per_cnt(per_cnt));

	always #2 clk_sys = ~clk_sys;

	task automatic fail(input string m);
		$display("Error at %0t: %s", $time, m);
		n_errors++;
	endtask : fail

	task automatic chk(input logic [31:0] g, input logic [31:0] e,
	                   input string m);
		compares++;
		if (g !== e) fail(m);
	endtask : chk

	task automatic give_verdict();
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict

	// One transfer; the expected answer is noted before the request goes out
	task automatic apb(input logic w, input logic [11:0] a,
	                   input logic [31:0] d, input logic [31:0] e,
	                   input logic err);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		apb_q.push_back('{data: e, err: err, rd: !w});
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 1'b0);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, e, 1'b0);
	endtask : rd

	task automatic wait_q();
		while (pwm_q.size() > 0) begin
			@(posedge clk_sys);
		end
	endtask : wait_q

	// Result watcher: takes the oldest note whenever a result appears
	always @(posedge clk_sys) begin
		if (psel && penable && pready === 1'b1) begin
			if (apb_q.size() == 0) begin
				fail("unexpected transfer");
			end else begin
				ae = apb_q.pop_front();
				compares++;
				if (pslverr !== ae.err || (ae.rd && prdata !== ae.data))
					fail("bus result");
			end
		end
		if (done === 1'b1 && pwm_q.size() > 0) begin
			pe = pwm_q.pop_front();
			compares++;
			if (per_cnt !== pe.per || (pe.use_hi && high_cnt !== pe.hi))
				fail("pwm period");
		end
	end

	initial begin
		repeat (60000) @(posedge clk_sys);
		fail("timeout");
		give_verdict();
	end

	initial begin
		clk_sys  = 1'b0;
		arst_n   = 1'b0;
		psel     = 1'b0;
		penable  = 1'b0;
		pwrite   = 1'b0;
		paddr    = 12'h000;
		pwdata   = 32'h0;
		n_errors = 0;
		compares = 0;
		void'($urandom(15));
		repeat (12) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		for (int i = 0; i < 8; i++) rd(12'(i * 4), 32'h0);
		apb(1'b1, 12'h020, 32'h1, 32'h0, 1'b1);
		apb(1'b0, 12'h020, 32'h0, 32'h0, 1'b1);
		$display("test reset_map done");

		wr(`A_CTRL, 32'h1);
		wr(`A_MODE, 32'h4a);
		for (int k = 0; k < 3; k++) begin
			hb = (k == 0) ? 8'hff : (k == 1) ? 8'h80 :
			     8'($urandom_range(254, 1));
			wr(`A_CMPL, {24'h0, hb});
			rd(`A_MODE, 32'h0a);
			wr(`A_CMPH, {24'h0, hb});
			rd(`A_MODE, 32'h4a);
			repeat (768) @(posedge clk_sys);
			pwm_q.push_back('{hi: 12'h100 - {4'h0, hb}, per: 12'h100,
			                  use_hi: 1'b1});
			wait_q();
		end
		$display("test duty8 done");

		// Longer cycles: compare is {high[2:0], low} cut to the length
		for (int l = 1; l < 4; l++) begin
			pv = 12'h100 << l;
			cv = {1'b0, hb[2:0], hb} & (pv - 12'h001);
			wr(`A_CFG, 32'(l));
			repeat (3 * pv) @(posedge clk_sys);
			pwm_q.push_back('{hi: pv - cv, per: pv,
			                  use_hi: 1'b1});
			wait_q();
		end
		wr(`A_CFG, 32'h0);
		$display("test long_cycle done");

		wr(`A_CMPL, 32'h0);
		wr(`A_CMPH, 32'h0);
		repeat (300) @(posedge clk_sys);
		cnt = 0;
		repeat (300) begin
			@(posedge clk_sys);
			if (pin !== 1'b1) cnt++;
		end
		chk(32'(cnt), 32'h0, "pin fell at full duty");
		$display("test full_duty done");

		for (int k = 0; k < 2; k++) begin
			wr(`A_MODE, (k == 0) ? 32'h0a : 32'h48);
			repeat (4) @(posedge clk_sys);
			cnt = 0;
			repeat (600) begin
				@(posedge clk_sys);
				if (pin !== 1'b0) cnt++;
			end
			chk(32'(cnt), 32'h0, "pin rose while disabled");
		end
		$display("test zero_duty done");

		for (int k = 0; k < 2; k++) begin
			wr(`A_MODE, (k == 0) ? 32'h4a : 32'h42);
			wr(`A_CTRL, 32'h1);
			wr(`A_STAT, 32'h3);
			repeat (600) @(posedge clk_sys);
			wr(`A_CTRL, 32'h0);
			repeat (4) @(posedge clk_sys);
			rd(`A_STAT, (k == 0) ? 32'h3 : 32'h2);
		end
		rd(`A_CFG, 32'h80);
		chk({31'h0, irq}, 32'h0, "irq while masked");
		wr(`A_MASK, 32'h2);
		repeat (2) @(posedge clk_sys);
		chk({31'h0, irq}, 32'h1, "irq not raised");
		wr(`A_STAT, 32'h3);
		repeat (2) @(posedge clk_sys);
		chk({31'h0, irq}, 32'h0, "irq not cleared");
		rd(`A_STAT, 32'h0);
		$display("test flags done");

		wr(`A_CNT, 32'h5);
		rd(`A_CNT, 32'h5);
		$display("test counter done");
		give_verdict();
	end
endmodule : counter_array_pwm_channel_tb

/* File: pin_load_model.sv */
`timescale 1ns/100ps
module pin_load_model (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	// Pin under observation
	input  wire logic        pin,
	// Per-period measurement
	output logic             done,
	output logic [11:0]      high_cnt,
	output logic [11:0]      per_cnt
);
	logic        pin_r;
	logic [11:0] hi_r;
	logic [11:0] per_r;

	// A period closes at each falling edge of the pin
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pin_r    <= 1'b0;
			hi_r     <= 12'h000;
			per_r    <= 12'h000;
			done     <= 1'b0;
			high_cnt <= 12'h000;
			per_cnt  <= 12'h000;
		end else begin
			pin_r <= pin;
			done  <= 1'b0;
			if (pin_r && !pin) begin
				done     <= 1'b1;
				high_cnt <= hi_r;
				per_cnt  <= per_r;
				hi_r     <= 12'h000;
				per_r    <= 12'h001;
			end else begin
				hi_r  <= hi_r + {11'h000, pin};
				per_r <= per_r + 12'h001;
			end
		end
	end
endmodule : pin_load_model

/* File: pwm_channel_defines.svh */
`ifndef PWM_CHANNEL_DEFINES_SVH
`define PWM_CHANNEL_DEFINES_SVH

// Register byte addresses
`define A_MODE     12'h000
`define A_CMPL     12'h004
`define A_CMPH     12'h008
`define A_CFG      12'h00c
`define A_STAT     12'h010
`define A_MASK     12'h014
`define A_CTRL     12'h018
`define A_CNT      12'h01c

// Field positions
`define B_CMP_EN   6
`define B_FLAG_EN  3
`define B_PWM      1
`define F_LEN_MSB  1
`define F_LEN_LSB  0
`define B_OVF_MIR  7
`define S_EVT      0
`define S_OVF      1
`define B_RUN      0
`define F_DIV_MSB  15
`define F_DIV_LSB  8
`define F_CNT_MSB  10
`define F_CNT_LSB  0
`define F_BYTE_MSB 7
`define F_BYTE_LSB 0
`define F_HI3_MSB  2

// Cycle length codes and counter limits
`define LEN_8      2'h0
`define LEN_9      2'h1
`define LEN_10     2'h2
`define MAX_8      11'h0ff
`define MAX_9      11'h1ff
`define MAX_10     11'h3ff
`define MAX_11     11'h7ff
`define CNT_ONE    11'h001

// Reset values and padding
`define RST_BYTE   8'h00
`define RST_CNT    11'h000
`define RST_LEN    2'h0
`define RST_FLAGS  2'h0
`define RST_WORD   32'h00000000
`define PAD3       3'h0
`define PAD21      21'h000000
`define PAD24      24'h000000
`define PAD30      30'h00000000

`endif

/* File: pwm_compare.sv */
`timescale 1ns/100ps
module pwm_compare (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	// Shared count
	count_bus_if.snk         bus,
	// Channel setup
	input  wire logic        active,
	input  wire logic [10:0] cmp_val,
	// Results
	output logic             pin,
	output logic             match,
	output logic             ovf
);
	pwm_pkg::cmp_state_t s_r;
	pwm_pkg::cmp_state_t s_nxt;
	logic                hit;

	assign hit = active && bus.tick &&
	             (pwm_pkg::nxt_count(bus.count, bus.len) == cmp_val);

	always_comb begin
		s_nxt       = s_r;
		s_nxt.match = 1'b0;
		s_nxt.ovf   = bus.wrap;
		if (bus.wrap) begin
			s_nxt.pin = 1'b0;
		end
		// Set after clear: compare value zero keeps the output high
		if (hit) begin
			s_nxt.pin   = 1'b1;
			s_nxt.match = 1'b1;
		end
		if (!active) begin
			s_nxt.pin = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= '{pin: 1'b0, match: 1'b0, ovf: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pin   = s_r.pin;
	assign match = s_r.match;
	assign ovf   = s_r.ovf;
endmodule : pwm_compare

/* File: pwm_pkg.sv */
package pwm_pkg;
	`include "pwm_channel_defines.svh"

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_RESP = 2'b10
	} bus_state_t;

	typedef logic [10:0] count_t;

	typedef struct packed {
		logic [7:0] pre;
		count_t     cnt;
	} tb_state_t;

	typedef struct packed {
		logic pin;
		logic match;
		logic ovf;
	} cmp_state_t;

	typedef struct packed {
		bus_state_t  st;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
		logic        cmp_en;
		logic        flag_en;
		logic        pwm;
		logic [7:0]  cmpl;
		logic [7:0]  cmph;
		logic [1:0]  len;
		logic [1:0]  stat;
		logic [1:0]  mask;
		logic        run;
		logic [7:0]  div;
		logic        irq;
	} top_state_t;

	localparam top_state_t TOP_RST = '{st: BUS_IDLE, pready: 1'b0,
		prdata: `RST_WORD, pslverr: 1'b0, cmp_en: 1'b0, flag_en: 1'b0,
		pwm: 1'b0, cmpl: `RST_BYTE, cmph: `RST_BYTE, len: `RST_LEN,
		stat: `RST_FLAGS, mask: `RST_FLAGS, run: 1'b0,
		div: `RST_BYTE, irq: 1'b0};

	function automatic count_t len_max(input logic [1:0] len);
		case (len)
			`LEN_8:  return `MAX_8;
			`LEN_9:  return `MAX_9;
			`LEN_10: return `MAX_10;
			default: return `MAX_11;
		endcase
	endfunction : len_max

	function automatic count_t nxt_count(input count_t c,
	                                     input logic [1:0] len);
		return (c + `CNT_ONE) & len_max(len);
	endfunction : nxt_count
endpackage : pwm_pkg
